/* File: design/fwp_map.svh */
// Offsets, field positions, command codes and counts for the write-protect block.
// Assumes inclusion by bare name from design and bench files.
`ifndef FWP_MAP_SVH
`define FWP_MAP_SVH

// Register byte offsets and control reset value
`define FWP_REG_CTRL        8'h00
`define FWP_REG_STATUS      8'h04
`define FWP_REG_MODE        8'h08
`define FWP_CTRL_RST        1'h0

// Status byte field positions
`define FWP_SR_READY        7
`define FWP_SR_ERASE_ERR    5
`define FWP_SR_PROG_ERR     4
`define FWP_SR_SUPPLY_ERR   3
`define FWP_SR_PROTECT_ERR  1

// AXI responses
`define FWP_RESP_OKAY       2'h0
`define FWP_RESP_SLVERR     2'h2

// Command codes
`define FWP_CMD_READ_ARRAY  8'hff
`define FWP_CMD_READ_STATUS 8'h70
`define FWP_CMD_CLEAR_STAT  8'h50
`define FWP_CMD_PROG_SETUP  8'h40
`define FWP_CMD_PROG_ALT    8'h10
`define FWP_CMD_ERASE_SETUP 8'h20
`define FWP_CMD_ERASE_CONF  8'hd0

// Block map: eight words per block
`define FWP_TOP_PARAM_FIRST 5'h0f
`define FWP_TOP_LOCK_A      5'h15
`define FWP_TOP_LOCK_B      5'h16
`define FWP_BOT_MAIN_FIRST  5'h08
`define FWP_BOT_LOCK_A      5'h00
`define FWP_BOT_LOCK_B      5'h01

// Write state machine timing in core_clk cycles and erased word value
`define FWP_PROG_CYCLES     8'h10
`define FWP_ERASE_LAST      8'h07
`define FWP_ERASED_WORD     16'hffff

`endif

/* File: design/fwp_pkg.sv */
// Types shared by the write-protect block.
// Assumes nothing outside itself.
package fwp_pkg;

    typedef enum logic [3:0] {
        CUI_ARRAY  = 4'b0001,
        CUI_STATUS = 4'b0010,
        CUI_PROG   = 4'b0100,
        CUI_ERASE  = 4'b1000
    } fwp_cui_e;

    typedef enum logic [2:0] {
        WSM_IDLE  = 3'b001,
        WSM_PROG  = 3'b010,
        WSM_ERASE = 3'b100
    } fwp_wsm_e;

    typedef enum logic [3:0] {
        PWR_RESET   = 4'b0001,
        PWR_STANDBY = 4'b0010,
        PWR_ACTIVE  = 4'b0100,
        PWR_APS     = 4'b1000
    } fwp_pwr_e;

    typedef struct packed {
        fwp_cui_e    command_interface;
        fwp_wsm_e    write_state_machine;
        fwp_pwr_e    pwr;
        logic [7:0]  cnt;
        logic [7:0]  op_addr;
        logic [15:0] op_data;
        logic        sr5;
        logic        sr4;
        logic        sr3;
        logic        sr1;
        logic        we_ce_low;
        logic        core_ok_d;
        logic [7:0]  last_addr;
        logic        auto_power_saving;
        logic [15:0] dq_out;
        logic        dq_drv;
        logic        top_boot;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } fwp_core_s;

endpackage

/* File: design/fwp_sync.sv */
// Three-stage pin synchroniser; an output bit follows once stages two and three agree.
// Assumes asynchronous pin inputs and a single core clock.
`timescale 1ns/1ps
module fwp_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } fwp_sync_s;

    fwp_sync_s st;
    fwp_sync_s next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // Bits still settling keep their old value
        next_st.q  = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.q);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;
endmodule

/* File: design/fwp_mem.sv */
// Small flash array model, 256 words of 16 bits, registered read.
// Assumes writes come only from the write state machine.
`timescale 1ns/1ps
module fwp_mem (
    input  wire logic        core_clk,
    input  wire logic        we,
    input  wire logic [7:0]  waddr,
    input  wire logic [15:0] wdata,
    input  wire logic [7:0]  raddr,
    output logic      [15:0] rdata
);
    logic [15:0] cells [0:255];

    // No reset: array contents are non-volatile by nature
    always_ff @(posedge core_clk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
        rdata <= cells[raddr];
    end
endmodule

/* File: design/fwp_core.sv */
// Write-protect gating, command interface and power modes of the flash device.
// Assumes AXI4-Lite master on core_clk; supply indications synchronous to core_clk.
`timescale 1ns/1ps
`include "fwp_map.svh"
module fwp_core (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        dev_reset_n,
    input  wire logic        write_protect_n,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] data_pins_in,
    output logic      [15:0] data_pins_out,
    output logic             data_pins_oe_n,
    input  wire logic        program_supply_ok,
    input  wire logic        core_supply_ok,
    output logic      [3:0]  power_mode,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    fwp_pkg::fwp_core_s st;
    fwp_pkg::fwp_core_s next_st;

    logic [4:0]  pin_q;
    logic [23:0] bus_q;
    logic        ce_q;
    logic        we_q;
    logic        oe_q;
    logic        rst_q;
    logic        wp_q;
    logic [7:0]  addr_q;
    logic [15:0] dq_q;
    logic [4:0]  blk;
    logic        lockable;
    logic        locked;
    logic        cmd_acc;
    logic        busy;
    logic        clr;
    logic        set5;
    logic        set4;
    logic        set3;
    logic        set1;
    logic        mem_we;
    logic [7:0]  mem_waddr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic [7:0]  sr_byte;

    // Stored inverted so reset reads as idle-high pins: no false write edge
    fwp_sync #(.W(5)) u_ctl_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin      (~{dev_reset_n, write_protect_n, oe_n, we_n, ce_n}),
        .q        (pin_q)
    );

    fwp_sync #(.W(24)) u_bus_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin      ({addr, data_pins_in}),
        .q        (bus_q)
    );

    fwp_mem u_mem (
        .core_clk (core_clk),
        .we       (mem_we),
        .waddr    (mem_waddr),
        .wdata    (mem_wdata),
        .raddr    (addr_q),
        .rdata    (mem_rdata)
    );

    assign ce_q   = !pin_q[0];
    assign we_q   = !pin_q[1];
    assign oe_q   = !pin_q[2];
    assign wp_q   = !pin_q[3];
    assign rst_q  = !pin_q[4];
    assign addr_q = bus_q[23:16];
    assign dq_q   = bus_q[15:0];
    assign blk    = addr_q[7:3];
    assign busy   = st.write_state_machine != fwp_pkg::WSM_IDLE;

    // Lockable set per boot configuration
    assign lockable = st.top_boot ?
        (blk < `FWP_TOP_PARAM_FIRST || blk == `FWP_TOP_LOCK_A || blk == `FWP_TOP_LOCK_B) :
        (blk >= `FWP_BOT_MAIN_FIRST || blk == `FWP_BOT_LOCK_A || blk == `FWP_BOT_LOCK_B);
    // Protection decode; supply levels already synchronous
    assign locked = !rst_q || !program_supply_ok || (!wp_q && lockable);
    // Write taken on write enable rising while chip enable was low
    assign cmd_acc = st.we_ce_low && we_q && rst_q && core_supply_ok;

    // Writes only while the machine runs a confirmed operation
    assign mem_we = rst_q && program_supply_ok &&
        ((st.write_state_machine == fwp_pkg::WSM_PROG && st.cnt == 8'h00) || st.write_state_machine == fwp_pkg::WSM_ERASE);
    assign mem_waddr = (st.write_state_machine == fwp_pkg::WSM_ERASE) ? {st.op_addr[7:3], st.cnt[2:0]} : st.op_addr;
    assign mem_wdata = (st.write_state_machine == fwp_pkg::WSM_ERASE) ? `FWP_ERASED_WORD : st.op_data;

    always_comb begin
        sr_byte = 8'h00;
        sr_byte[`FWP_SR_READY]       = !busy;
        sr_byte[`FWP_SR_ERASE_ERR]   = st.sr5;
        sr_byte[`FWP_SR_PROG_ERR]    = st.sr4;
        sr_byte[`FWP_SR_SUPPLY_ERR]  = st.sr3;
        sr_byte[`FWP_SR_PROTECT_ERR] = st.sr1;
    end

    always_comb begin
        next_st           = st;
        clr               = 1'b0;
        set5              = 1'b0;
        set4              = 1'b0;
        set3              = 1'b0;
        set1              = 1'b0;
        next_st.we_ce_low = !we_q && !ce_q;
        next_st.core_ok_d = core_supply_ok;

        // Command decode; latched mode moves on host writes and on the reset and supply clears below
        if (cmd_acc && busy) begin
            if (dq_q[7:0] == `FWP_CMD_READ_STATUS) begin
                next_st.command_interface = fwp_pkg::CUI_STATUS;
            end
        end else if (cmd_acc) begin
            unique case (st.command_interface)
                fwp_pkg::CUI_PROG: begin
                    next_st.command_interface = fwp_pkg::CUI_STATUS;
                    if (!program_supply_ok) begin
                        set3 = 1'b1;
                        set4 = 1'b1;
                    end else if (locked) begin
                        set1 = 1'b1;
                        set4 = 1'b1;
                    end else begin
                        next_st.write_state_machine     = fwp_pkg::WSM_PROG;
                        next_st.cnt     = `FWP_PROG_CYCLES;
                        next_st.op_addr = addr_q;
                        next_st.op_data = dq_q;
                    end
                end
                fwp_pkg::CUI_ERASE: begin
                    next_st.command_interface = fwp_pkg::CUI_STATUS;
                    if (dq_q[7:0] != `FWP_CMD_ERASE_CONF) begin
                        set5 = 1'b1;
                        set4 = 1'b1;
                    end else if (!program_supply_ok) begin
                        set3 = 1'b1;
                        set5 = 1'b1;
                    end else if (locked) begin
                        set1 = 1'b1;
                        set5 = 1'b1;
                    end else begin
                        next_st.write_state_machine     = fwp_pkg::WSM_ERASE;
                        next_st.cnt     = `FWP_ERASE_LAST;
                        next_st.op_addr = {addr_q[7:3], 3'h0};
                    end
                end
                fwp_pkg::CUI_ARRAY, fwp_pkg::CUI_STATUS: begin
                    case (dq_q[7:0])
                        `FWP_CMD_READ_ARRAY:  next_st.command_interface = fwp_pkg::CUI_ARRAY;
                        `FWP_CMD_READ_STATUS: next_st.command_interface = fwp_pkg::CUI_STATUS;
                        `FWP_CMD_CLEAR_STAT:  clr = 1'b1;
                        `FWP_CMD_PROG_SETUP,
                        `FWP_CMD_PROG_ALT:    next_st.command_interface = fwp_pkg::CUI_PROG;
                        `FWP_CMD_ERASE_SETUP: next_st.command_interface = fwp_pkg::CUI_ERASE;
                        default: begin
                            next_st.command_interface = fwp_pkg::CUI_STATUS;
                            set5 = 1'b1;
                            set4 = 1'b1;
                        end
                    endcase
                end
            endcase
        end

        // Operation runs on regardless of chip enable
        unique case (st.write_state_machine)
            fwp_pkg::WSM_IDLE: begin
            end
            fwp_pkg::WSM_PROG: begin
                if (!program_supply_ok) begin
                    set3 = 1'b1;
                    set4 = 1'b1;
                    next_st.write_state_machine = fwp_pkg::WSM_IDLE;
                end else if (st.cnt == 8'h00) begin
                    next_st.write_state_machine = fwp_pkg::WSM_IDLE;
                end else begin
                    next_st.cnt = st.cnt - 8'h01;
                end
            end
            fwp_pkg::WSM_ERASE: begin
                if (!program_supply_ok) begin
                    set3 = 1'b1;
                    set5 = 1'b1;
                    next_st.write_state_machine = fwp_pkg::WSM_IDLE;
                end else if (st.cnt == 8'h00) begin
                    next_st.write_state_machine = fwp_pkg::WSM_IDLE;
                end else begin
                    next_st.cnt = st.cnt - 8'h01;
                end
            end
        endcase

        // Sticky errors; a set in the clear cycle survives
        next_st.sr5 = set5 || (st.sr5 && !clr);
        next_st.sr4 = set4 || (st.sr4 && !clr);
        next_st.sr3 = set3 || (st.sr3 && !clr);
        next_st.sr1 = set1 || (st.sr1 && !clr);

        // Reset pin, core supply low or its return abandon the command mode and any operation
        if (!rst_q || !core_supply_ok || (core_supply_ok && !st.core_ok_d)) begin
            next_st.command_interface = fwp_pkg::CUI_ARRAY;
            next_st.write_state_machine = fwp_pkg::WSM_IDLE;
        end

        // Power mode and output drive
        next_st.last_addr = addr_q;
        next_st.auto_power_saving       = addr_q == st.last_addr;
        if (!rst_q) begin
            next_st.pwr = fwp_pkg::PWR_RESET;
        end else if (!ce_q) begin
            next_st.pwr = st.auto_power_saving ? fwp_pkg::PWR_APS : fwp_pkg::PWR_ACTIVE;
        end else if (busy || st.command_interface == fwp_pkg::CUI_PROG || st.command_interface == fwp_pkg::CUI_ERASE) begin
            next_st.pwr = fwp_pkg::PWR_ACTIVE;
        end else begin
            next_st.pwr = fwp_pkg::PWR_STANDBY;
        end
        // Same address gives same word, so outputs stay static in saving mode
        next_st.dq_out = (st.command_interface == fwp_pkg::CUI_ARRAY) ? mem_rdata : {8'h00, sr_byte};
        next_st.dq_drv = rst_q && !ce_q && !oe_q;

        // AXI4-Lite write channel
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_got  = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.aw_got && st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            if (st.aw_addr == `FWP_REG_CTRL) begin
                next_st.bresp = `FWP_RESP_OKAY;
                if (st.w_strb[0]) begin
                    next_st.top_boot = st.w_data[0];
                end
            end else begin
                next_st.bresp = `FWP_RESP_SLVERR;
            end
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // AXI4-Lite read channel
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = `FWP_RESP_OKAY;
            case (s_axi_araddr)
                `FWP_REG_CTRL:   next_st.rdata = {31'h0, st.top_boot};
                `FWP_REG_STATUS: next_st.rdata = {20'h0, st.pwr, sr_byte};
                `FWP_REG_MODE:   next_st.rdata = {25'h0, st.write_state_machine, st.command_interface};
                default: begin
                    next_st.rdata = 32'h0;
                    next_st.rresp = `FWP_RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
    end

    // Power-up lands in read array
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '{command_interface: fwp_pkg::CUI_ARRAY, write_state_machine: fwp_pkg::WSM_IDLE,
                    pwr: fwp_pkg::PWR_RESET, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign data_pins_out  = st.dq_out;
    assign data_pins_oe_n = !st.dq_drv;
    assign power_mode     = st.pwr;
    assign s_axi_awready  = !st.aw_got && !st.bvalid;
    assign s_axi_wready   = !st.w_got && !st.bvalid;
    assign s_axi_bvalid   = st.bvalid;
    assign s_axi_bresp    = st.bresp;
    assign s_axi_arready  = !st.rvalid;
    assign s_axi_rvalid   = st.rvalid;
    assign s_axi_rdata    = st.rdata;
    assign s_axi_rresp    = st.rresp;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_SUPPLY_REFUSE: assert property (
        cmd_acc && !busy && st.command_interface == fwp_pkg::CUI_PROG && !program_supply_ok
        |=> st.sr3 && st.sr4 && st.write_state_machine == fwp_pkg::WSM_IDLE)
        else $error("supply low program not refused");
    AST_WP_REFUSE: assert property (
        cmd_acc && !busy && st.command_interface == fwp_pkg::CUI_PROG && program_supply_ok && !wp_q
        && lockable |=> st.sr1 && st.write_state_machine == fwp_pkg::WSM_IDLE)
        else $error("locked block program not refused");
    AST_TOP_SET: assert property (
        st.top_boot |-> ((blk == 5'h15 || blk == 5'h16 || blk == 5'h0e) == lockable
        || !(blk == 5'h15 || blk == 5'h16 || blk == 5'h0e || blk == 5'h0f)))
        else $error("top boot lockable set wrong");
    AST_BOT_SET: assert property (
        !st.top_boot && (blk == 5'h01 || blk == 5'h02 || blk == 5'h08)
        |-> lockable == (blk != 5'h02))
        else $error("bottom boot lockable set wrong");
    AST_FREE_BLOCK: assert property (
        cmd_acc && !busy && st.command_interface == fwp_pkg::CUI_PROG && program_supply_ok && !lockable
        && rst_q |=> st.write_state_machine == fwp_pkg::WSM_PROG)
        else $error("unlocked program not started");
    AST_RESET_PIN: assert property (
        !rst_q |=> st.command_interface == fwp_pkg::CUI_ARRAY && !busy && !st.dq_drv
        && st.pwr == fwp_pkg::PWR_RESET)
        else $error("reset pin did not disable device");
    AST_WRITE_GATE: assert property (
        !busy && !(cmd_acc && (st.command_interface == fwp_pkg::CUI_PROG || st.command_interface == fwp_pkg::CUI_ERASE))
        |=> !busy)
        else $error("machine started without two-step sequence");
    AST_STANDBY: assert property (
        ce_q && rst_q |=> !st.dq_drv)
        else $error("outputs driven with chip enable high");
    AST_BUSY_RUNS: assert property (
        st.write_state_machine == fwp_pkg::WSM_PROG && st.cnt != 8'h00 && ce_q && rst_q && core_supply_ok
        && program_supply_ok |=> st.write_state_machine == fwp_pkg::WSM_PROG && st.cnt == $past(st.cnt) - 8'h01)
        else $error("program stopped by chip enable");
    AST_STICKY: assert property (
        st.sr1 && !(cmd_acc && !busy && dq_q[7:0] == `FWP_CMD_CLEAR_STAT
        && st.command_interface != fwp_pkg::CUI_PROG && st.command_interface != fwp_pkg::CUI_ERASE) |=> st.sr1)
        else $error("protect error cleared without command");
    AST_ACTIVE: assert property (
        !ce_q && rst_q |=> st.pwr == fwp_pkg::PWR_ACTIVE || st.pwr == fwp_pkg::PWR_APS)
        else $error("not active with chip enable low");
endmodule

/* File: tb/fwp_host.sv */
// Host pin model: command writes and array reads on the flash pins.
// Assumes the bench resolves the shared data wire from the device output enable.
`timescale 1ns/1ps
module fwp_host (
    input  wire logic        core_clk,
    output logic             ce_n,
    output logic             we_n,
    output logic             oe_n,
    output logic             dev_reset_n,
    output logic             write_protect_n,
    output logic      [7:0]  addr,
    output logic      [15:0] dq,
    input  wire logic [15:0] dq_wire
);
    initial begin
        {ce_n, we_n, oe_n, dev_reset_n, write_protect_n} = 5'h1f;
        addr = 8'h00;
        dq = 16'h0000;
    end
    // Held six cycles so the three-flop pin synchronisers settle
    task automatic pin_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        {ce_n, we_n, oe_n} <= 3'h1;
        addr <= a;
        dq <= d;
        repeat (6) @(posedge core_clk);
        we_n <= 1'h1;
        repeat (6) @(posedge core_clk);
        ce_n <= 1'h1;
        dq <= ~d; // Bus driven to the inverted word, no stale value
    endtask
    // Status mode persists after operations, so read array goes first
    task automatic rd_arr(input logic [7:0] a, output logic [15:0] v);
        pin_wr(a, 16'h00ff);
        @(posedge core_clk);
        {ce_n, oe_n} <= 2'h0;
        addr <= a;
        repeat (10) @(posedge core_clk);
        v = dq_wire;
    endtask
endmodule

/* File: tb/fwp_core_tb.sv */
// Self-checking bench for fwp_core: AXI4-Lite register tasks and pin host.
// Assumes fwp_host on the pins; one 50 MHz clock.
`timescale 1ns/1ps
`include "fwp_map.svh"
module fwp_core_tb;
    localparam logic [15:0] pg = {8'h00, `FWP_CMD_PROG_SETUP};
    localparam logic [15:0] es = {8'h00, `FWP_CMD_ERASE_SETUP};
    localparam logic [15:0] ec = {8'h00, `FWP_CMD_ERASE_CONF};
    localparam logic [15:0] cs = {8'h00, `FWP_CMD_CLEAR_STAT};
    localparam logic [1:0]  ok = `FWP_RESP_OKAY;
    localparam logic [1:0]  se = `FWP_RESP_SLVERR;
    logic        core_clk = 1'h0, rst_n = 1'h0, psup = 1'h1, csup = 1'h1;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf, pm;
    logic        ce_n, we_n, oe_n, rp_n, wp_n, dq_oe_n, awready, wready, bvalid, arready, rvalid;
    logic [7:0]  addr;
    logic [15:0] hdq, dq_out, dq_wire;
    logic [1:0]  bresp, rresp;
    int          err_count = 0, tests_run = 0;
    assign dq_wire = dq_oe_n ? hdq : dq_out;
    always #10 core_clk = ~core_clk;
    fwp_host host (.core_clk(core_clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .dev_reset_n(rp_n), .write_protect_n(wp_n), .addr(addr), .dq(hdq), .dq_wire(dq_wire));
    fwp_core dut (.core_clk(core_clk), .rst_n(rst_n), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .dev_reset_n(rp_n), .write_protect_n(wp_n), .addr(addr), .data_pins_in(dq_wire),
        .data_pins_out(dq_out), .data_pins_oe_n(dq_oe_n), .program_supply_ok(psup),
        .core_supply_ok(csup), .power_mode(pm), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask
    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic [1:0] r;
        axw(a, d, r);
        chk({30'h0, r}, {30'h0, e});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axr(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask
    // Two-step sequence, then poll until the machine reports ready
    task automatic op(input logic [7:0] a, input logic [15:0] c, input logic [15:0] d,
                      input logic [7:0] e);
        logic [31:0] st;
        logic [1:0]  r;
        host.pin_wr(a, c);
        host.pin_wr(a, d);
        st = 32'h0;
        repeat (60) if (!st[7]) axr(`FWP_REG_STATUS, st, r);
        chk({24'h0, st[7:0]}, {24'h0, e});
    endtask
    task automatic row(input logic t, input logic w, input logic s, input logic [7:0] a,
                       input logic [15:0] c, input logic [15:0] d, input logic [7:0] e);
        wchk(`FWP_REG_CTRL, {31'h0, t}, ok);
        @(posedge core_clk);
        host.write_protect_n <= w;
        psup <= s;
        op(a, c, d, e);
        host.pin_wr(a, cs);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] v;
        host.rd_arr(a, v);
        chk({16'h0, v}, {16'h0, e});
        chk({28'h0, pm}, 32'h8);
    endtask
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'h1;
        repeat (6) @(posedge core_clk);
        rchk(`FWP_REG_CTRL, 32'h0, ok);
        rchk(`FWP_REG_MODE, 32'h11, ok);
        rchk(8'h0c, 32'h0, se);
        wchk(`FWP_REG_STATUS, 32'h0, se);
        row(0, 0, 1, 8'h00, pg, 16'h1234, 8'h92);
        row(0, 0, 1, 8'h08, es, ec, 8'ha2);
        row(0, 0, 1, 8'h40, pg, 16'h1111, 8'h92);
        row(0, 1, 0, 8'h10, pg, 16'h1111, 8'h98);
        row(0, 1, 0, 8'h10, es, ec, 8'ha8);
        row(0, 1, 1, 8'h00, {8'h00, `FWP_CMD_PROG_ALT}, 16'h5555, 8'h80);
        row(0, 1, 1, 8'h18, es, 16'h0033, 8'hb0);
        row(1, 0, 1, 8'ha8, pg, 16'h1111, 8'h92);
        row(1, 0, 1, 8'hb0, pg, 16'h1111, 8'h92);
        row(1, 0, 1, 8'h70, pg, 16'h1111, 8'h92);
        row(1, 0, 1, 8'h78, pg, 16'h2222, 8'h80);
        row(1, 1, 1, 8'h10, pg, 16'habcd, 8'h80);
        rd(8'h10, 16'habcd);
        row(0, 1, 1, 8'h10, es, ec, 8'h80);
        rd(8'h10, 16'hffff);
        @(posedge core_clk);
        host.write_protect_n <= 1'h0;
        op(8'h00, pg, 16'h1234, 8'h92);
        op(8'h20, pg, 16'h4321, 8'h92);
        host.pin_wr(8'h20, cs);
        rd(8'h20, 16'h4321);
        host.ce_n <= 1'h1;
        repeat (8) @(posedge core_clk);
        chk({27'h0, dq_oe_n, pm}, 32'h12);
        host.dev_reset_n <= 1'h0;
        host.pin_wr(8'h20, 16'h0070);
        @(posedge core_clk);
        {host.ce_n, host.oe_n} <= 2'h0;
        repeat (8) @(posedge core_clk);
        chk({27'h0, dq_oe_n, pm}, 32'h11);
        {host.ce_n, host.oe_n, host.dev_reset_n} <= 3'h7;
        rchk(`FWP_REG_MODE, 32'h11, ok);
        host.pin_wr(8'h20, 16'h0070);
        psup <= 1'h0;
        repeat (8) @(posedge core_clk);
        psup <= 1'h1;
        rchk(`FWP_REG_MODE, 32'h12, ok);
        csup <= 1'h0;
        repeat (4) @(posedge core_clk);
        csup <= 1'h1;
        rchk(`FWP_REG_MODE, 32'h11, ok);
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        end_sim();
    end
endmodule
